// file: logic/link_slot_regs.sv
`timescale 1ns/1ns

// Notes on behaviour
// - max link speed bits 3:0 read 0001
// - max lane width bits 9:4, reset x1
// - power-management support bits 11:10 read ASPM_SUP, default 11
// - control bits 1:0 select power level, reset 00
// - completion boundary bit 3 reads zero
// - negotiated speed bits 19:16 read one
// - slot bits 0,2,3,4,6 follow hot-plug strap
module link_slot_regs #(
    parameter logic [5:0] MAX_WIDTH = link_slot_pkg::MAX_WIDTH_RST,
    parameter logic [1:0] ASPM_SUP = link_slot_pkg::ASPM_SUP_RST
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic hotplug_strap,
    input wire link_slot_pkg::link_state_t link_state,
    output link_slot_pkg::link_ctl_t link_ctl
);

    ////////////////////////////////////////////////////////////////////////
    // elaboration checks: only codes the capability field can carry
    function automatic logic width_legal(input logic [5:0] w);
        width_legal = (w == link_slot_pkg::WIDTH_X1)
            || (w == link_slot_pkg::WIDTH_X2)
            || (w == link_slot_pkg::WIDTH_X4)
            || (w == link_slot_pkg::WIDTH_X8)
            || (w == link_slot_pkg::WIDTH_X12)
            || (w == link_slot_pkg::WIDTH_X16)
            || (w == link_slot_pkg::WIDTH_X32);
    endfunction : width_legal

    if (!width_legal(MAX_WIDTH)) begin : g_bad_width
        $error("MAX_WIDTH is not a legal lane code");
    end
    if ((ASPM_SUP != link_slot_pkg::ASPM_SUP_L0S)
        && (ASPM_SUP != link_slot_pkg::ASPM_SUP_BOTH)) begin : g_bad_aspm
        $error("ASPM_SUP must be L0s only or both");
    end

    ////////////////////////////////////////////////////////////////////////
    // state of the block
    typedef struct packed {
        logic [31:0] rdata;
        logic err;
        link_slot_pkg::link_ctl_t ctl;
    } regs_st_t;

    regs_st_t st_q;
    regs_st_t st_d;
    logic hp_en;
    logic setup;
    logic access;
    logic hit_cap;
    logic hit_ctl;
    logic hit_slot;
    logic [31:0] cap_word;
    logic [31:0] ctl_word;
    logic [31:0] slot_word;

    ////////////////////////////////////////////////////////////////////////
    // the strap is a pin, so it is synchronised before use
    strap_sync u_strap_sync (
        .pclk(pclk),
        .presetn(presetn),
        .pin(hotplug_strap),
        .level(hp_en)
    );

    ////////////////////////////////////////////////////////////////////////
    // apb phase and address decode
    assign setup = psel && !penable;
    assign access = psel && penable;
    assign hit_cap = (paddr == link_slot_pkg::LINK_CAP_OFF);
    assign hit_ctl = (paddr == link_slot_pkg::LINK_CTL_OFF);
    assign hit_slot = (paddr == link_slot_pkg::SLOT_CAP_OFF);

    ////////////////////////////////////////////////////////////////////////
    // read words; every bit not named here reads zero
    always_comb begin
        cap_word = 32'h0000_0000;
        cap_word[link_slot_pkg::MAX_SPEED_LSB +: 4] =
            link_slot_pkg::MAX_SPEED_RST;
        cap_word[link_slot_pkg::MAX_WIDTH_LSB +: 6] = MAX_WIDTH;
        cap_word[link_slot_pkg::ASPM_SUP_LSB +: 2] = ASPM_SUP;
        cap_word[link_slot_pkg::L0S_LAT_LSB +: 3] =
            link_slot_pkg::L0S_LAT_RST;
        cap_word[link_slot_pkg::L1_LAT_LSB +: 3] =
            link_slot_pkg::L1_LAT_RST;
        cap_word[link_slot_pkg::PORT_NUM_LSB +: 8] =
            link_slot_pkg::PORT_NUM_RST;
    end

    always_comb begin
        ctl_word = 32'h0000_0000;
        ctl_word[link_slot_pkg::ASPM_CTL_LSB +: 2] = st_q.ctl.aspm_ctl;
        ctl_word[link_slot_pkg::READ_COMPLETION_BOUNDARY_BIT] =
            1'b0;
        ctl_word[link_slot_pkg::COMMON_CLK_BIT] = st_q.ctl.common_clk;
        ctl_word[link_slot_pkg::EXT_SYNC_BIT] = st_q.ctl.ext_sync;
        ctl_word[link_slot_pkg::LINK_SPEED_LSB +: 4] =
            link_slot_pkg::LINK_SPEED_RST;
        ctl_word[link_slot_pkg::NEG_WIDTH_LSB +: 6] = link_state.neg_width;
        ctl_word[link_slot_pkg::TRAIN_ERR_BIT] = link_state.train_err;
        ctl_word[link_slot_pkg::TRAINING_BIT] = link_state.training;
        ctl_word[link_slot_pkg::SLOT_CLK_BIT] = link_slot_pkg::SLOT_CLK_RST;
    end

    // hot-plug presence bits are a live copy of the synchronised strap
    always_comb begin
        slot_word = 32'h0000_0000;
        slot_word[link_slot_pkg::ATTN_BTN_BIT] = hp_en;
        slot_word[link_slot_pkg::MRL_BIT] = hp_en;
        slot_word[link_slot_pkg::ATTN_IND_BIT] = hp_en;
        slot_word[link_slot_pkg::PWR_IND_BIT] = hp_en;
        slot_word[link_slot_pkg::HP_CAP_BIT] = hp_en;
        slot_word[link_slot_pkg::PWR_VAL_LSB +: 8] =
            link_slot_pkg::PWR_VAL_RST;
        slot_word[link_slot_pkg::PWR_SCALE_LSB +: 2] =
            link_slot_pkg::PWR_SCALE_RST;
        slot_word[link_slot_pkg::SLOT_NUM_LSB +: 13] =
            link_slot_pkg::SLOT_NUM_RST;
    end

    ////////////////////////////////////////////////////////////////////////
    // next state: read data and error are captured in the setup cycle so
    // that the slave answers with zero wait states from flip-flops
    always_comb begin
        st_d = st_q;
        if (setup) begin
            st_d.err = !(hit_cap || hit_ctl || hit_slot);
            if (pwrite || !(hit_cap || hit_ctl || hit_slot)) begin
                st_d.rdata = 32'h0000_0000;
            end else if (hit_cap) begin
                st_d.rdata = cap_word;
            end else if (hit_ctl) begin
                st_d.rdata = ctl_word;
            end else begin
                st_d.rdata = slot_word;
            end
        end
        // only the writable bits of byte 0 at the control word take data;
        // everything else, including the whole capability words, is
        // dropped on the floor
        if (access && pwrite && hit_ctl && pstrb[0]) begin
            st_d.ctl.aspm_ctl =
                pwdata[link_slot_pkg::ASPM_CTL_LSB +: 2];
            st_d.ctl.common_clk = pwdata[link_slot_pkg::COMMON_CLK_BIT];
            st_d.ctl.ext_sync = pwdata[link_slot_pkg::EXT_SYNC_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q.rdata <= 32'h0000_0000;
            st_q.err <= 1'b0;
            st_q.ctl.aspm_ctl <= link_slot_pkg::ASPM_CTL_RST;
            st_q.ctl.common_clk <= 1'b0;
            st_q.ctl.ext_sync <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs; ready and pslverr are the combinational ones
    assign pready = access;
    assign prdata = st_q.rdata;
    assign pslverr = access && st_q.err;
    assign link_ctl = st_q.ctl;

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence rd_setup(logic [7:0] off);
        psel && !penable && !pwrite && (paddr == off);
    endsequence

    sequence wr_done(logic [7:0] off);
        psel && penable && pwrite && (paddr == off);
    endsequence

    max_speed_a: assert property (
        rd_setup(link_slot_pkg::LINK_CAP_OFF)
        |=> pready && (prdata[3:0] == 4'h1)
    ) else $error("max link speed not 0001");

    max_width_a: assert property (
        rd_setup(link_slot_pkg::LINK_CAP_OFF)
        |=> (prdata[9:4] == MAX_WIDTH) && (prdata[9:4] != 6'h00)
    ) else $error("max lane width wrong");

    aspm_support_a: assert property (
        rd_setup(link_slot_pkg::LINK_CAP_OFF)
        |=> prdata[11:10] == ASPM_SUP
    ) else $error("power support field wrong");

    aspm_write_a: assert property (
        wr_done(link_slot_pkg::LINK_CTL_OFF) ##0 pstrb[0]
        |=> link_ctl.aspm_ctl == $past(pwdata[1:0])
    ) else $error("power control write lost");

    aspm_readback_a: assert property (
        wr_done(link_slot_pkg::LINK_CTL_OFF) ##0 pstrb[0]
        ##1 !psel ##1 rd_setup(link_slot_pkg::LINK_CTL_OFF)
        |=> prdata[1:0] == $past(pwdata[1:0], 3)
    ) else $error("power control readback wrong");

    bound_zero_a: assert property (
        rd_setup(link_slot_pkg::LINK_CTL_OFF) |=> !prdata[3]
    ) else $error("completion boundary bit set");

    neg_speed_a: assert property (
        rd_setup(link_slot_pkg::LINK_CTL_OFF)
        |=> prdata[19:16] == 4'h1
    ) else $error("negotiated speed not one");

    hp_bits_a: assert property (
        rd_setup(link_slot_pkg::SLOT_CAP_OFF)
        |=> (prdata[6:0] & 7'h5d) == ($past(hp_en) ? 7'h5d : 7'h00)
    ) else $error("hot-plug bits do not follow strap");

    ro_write_a: assert property (
        psel && penable && pwrite && !hit_ctl |=> $stable(link_ctl)
    ) else $error("write to read-only word changed state");

    unmapped_err_a: assert property (
        psel && !penable && !(hit_cap || hit_ctl || hit_slot)
        ##1 psel && penable
        |-> pslverr && pready && (prdata == 32'h0000_0000)
    ) else $error("unmapped access not refused");

    ////////////////////////////////////////////////////////////////////////
    // reset values, bus behaviour and the fixed fields of every word
    ctl_reset_a: assert property (
        $rose(presetn)
        |-> (link_ctl.aspm_ctl == link_slot_pkg::ASPM_CTL_RST)
            && !link_ctl.common_clk && !link_ctl.ext_sync
    ) else $error("control bits not cleared by reset");

    // read data stands from one setup cycle to the next
    rdata_hold_a: assert property (
        !(psel && !penable) |=> $stable(prdata)
    ) else $error("read data moved outside a setup cycle");

    write_no_data_a: assert property (
        psel && !penable && pwrite |=> prdata == 32'h0000_0000
    ) else $error("write cycle returned read data");

    strobe_low_a: assert property (
        wr_done(link_slot_pkg::LINK_CTL_OFF) ##0 !pstrb[0]
        |=> $stable(link_ctl)
    ) else $error("write with byte 0 strobe low took effect");

    ctl_bits_write_a: assert property (
        wr_done(link_slot_pkg::LINK_CTL_OFF) ##0 pstrb[0]
        |=> (link_ctl.common_clk == $past(pwdata[6]))
            && (link_ctl.ext_sync == $past(pwdata[7]))
    ) else $error("clock config or sync bit write lost");

    ctl_readonly_a: assert property (
        rd_setup(link_slot_pkg::LINK_CTL_OFF)
        |=> (prdata[15:8] == 8'h00) && (prdata[5:4] == 2'h0) && !prdata[2]
            && (prdata[28] == link_slot_pkg::SLOT_CLK_RST)
            && (prdata[31:29] == 3'h0)
    ) else $error("read-only control bits not at fixed values");

    // status half is a same-cycle copy of the training logic's state
    status_copy_a: assert property (
        rd_setup(link_slot_pkg::LINK_CTL_OFF)
        |=> (prdata[25:20] == $past(link_state.neg_width))
            && (prdata[26] == $past(link_state.train_err))
            && (prdata[27] == $past(link_state.training))
    ) else $error("link state not reported");

    slot_fixed_a: assert property (
        rd_setup(link_slot_pkg::SLOT_CAP_OFF)
        |=> !prdata[1] && !prdata[5] && (prdata[18:17] == 2'h0)
            && (prdata[14:7] == link_slot_pkg::PWR_VAL_RST)
            && (prdata[16:15] == link_slot_pkg::PWR_SCALE_RST)
            && (prdata[31:19] == link_slot_pkg::SLOT_NUM_RST)
    ) else $error("fixed slot fields wrong");

    cap_fixed_a: assert property (
        rd_setup(link_slot_pkg::LINK_CAP_OFF)
        |=> (prdata[14:12] == link_slot_pkg::L0S_LAT_RST)
            && (prdata[17:15] == link_slot_pkg::L1_LAT_RST)
            && (prdata[23:18] == 6'h00)
            && (prdata[31:24] == link_slot_pkg::PORT_NUM_RST)
    ) else $error("fixed capability fields wrong");

endmodule : link_slot_regs

// file: inc/link_slot_pkg.sv
package link_slot_pkg;

    // register byte offsets on the apb side
    localparam logic [7:0] LINK_CAP_OFF = 8'hbc;
    localparam logic [7:0] LINK_CTL_OFF = 8'hc0;
    localparam logic [7:0] SLOT_CAP_OFF = 8'hc4;

    // link capability fields
    localparam int MAX_SPEED_LSB = 0;
    localparam int MAX_WIDTH_LSB = 4;
    localparam int ASPM_SUP_LSB = 10;
    localparam int L0S_LAT_LSB = 12;
    localparam int L1_LAT_LSB = 15;
    localparam int PORT_NUM_LSB = 24;

    // link control (low half) and link state report (high half) fields
    localparam int ASPM_CTL_LSB = 0;
    localparam int READ_COMPLETION_BOUNDARY_BIT = 3;
    localparam int COMMON_CLK_BIT = 6;
    localparam int EXT_SYNC_BIT = 7;
    localparam int LINK_SPEED_LSB = 16;
    localparam int NEG_WIDTH_LSB = 20;
    localparam int TRAIN_ERR_BIT = 26;
    localparam int TRAINING_BIT = 27;
    localparam int SLOT_CLK_BIT = 28;

    // slot capability fields
    localparam int ATTN_BTN_BIT = 0;
    localparam int MRL_BIT = 2;
    localparam int ATTN_IND_BIT = 3;
    localparam int PWR_IND_BIT = 4;
    localparam int HP_CAP_BIT = 6;
    localparam int PWR_VAL_LSB = 7;
    localparam int PWR_SCALE_LSB = 15;
    localparam int SLOT_NUM_LSB = 19;

    // reset and fixed values
    localparam logic [3:0] MAX_SPEED_RST = 4'h1;
    localparam logic [5:0] MAX_WIDTH_RST = 6'h01;
    localparam logic [1:0] ASPM_SUP_RST = 2'h3;
    localparam logic [2:0] L0S_LAT_RST = 3'h3;
    localparam logic [2:0] L1_LAT_RST = 3'h6;
    localparam logic [7:0] PORT_NUM_RST = 8'h00;
    localparam logic [1:0] ASPM_CTL_RST = 2'h0;
    localparam logic [3:0] LINK_SPEED_RST = 4'h1;
    localparam logic SLOT_CLK_RST = 1'b1;
    localparam logic [7:0] PWR_VAL_RST = 8'h00;
    localparam logic [1:0] PWR_SCALE_RST = 2'h0;
    localparam logic [12:0] SLOT_NUM_RST = 13'h0000;

    // lane width codes
    localparam logic [5:0] WIDTH_X1 = 6'h01;
    localparam logic [5:0] WIDTH_X2 = 6'h02;
    localparam logic [5:0] WIDTH_X4 = 6'h04;
    localparam logic [5:0] WIDTH_X8 = 6'h08;
    localparam logic [5:0] WIDTH_X12 = 6'h0c;
    localparam logic [5:0] WIDTH_X16 = 6'h10;
    localparam logic [5:0] WIDTH_X32 = 6'h20;

    // power-management support codes
    localparam logic [1:0] ASPM_SUP_L0S = 2'h1;
    localparam logic [1:0] ASPM_SUP_BOTH = 2'h3;

    // software-owned link control bits
    typedef struct packed {
        logic ext_sync;
        logic common_clk;
        logic [1:0] aspm_ctl;
    } link_ctl_t;

    // state handed over by the training logic, same clock
    typedef struct packed {
        logic [5:0] neg_width;
        logic train_err;
        logic training;
    } link_state_t;

endpackage : link_slot_pkg

// file: logic/strap_sync.sv
`timescale 1ns/1ns

// three-stage pin synchroniser; output moves only when stages two and
// three agree, so a single metastable sample never reaches the registers
module strap_sync (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pin,
    output logic level
);

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic out;
    } sync_st_t;

    sync_st_t st_q;
    sync_st_t st_d;

    ////////////////////////////////////////////////////////////////////////
    // next state: s1 feeds only s2
    always_comb begin
        st_d = st_q;
        st_d.s1 = pin;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        if (st_q.s2 == st_q.s3) begin
            st_d.out = st_q.s3;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign level = st_q.out;

endmodule : strap_sync

// file: verif/test_link_slot_regs.sv
`timescale 1ns/1ns

module test_link_slot_regs;

    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic hotplug_strap;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    logic [1:0] k;
    link_slot_pkg::link_state_t state_in;
    link_slot_pkg::link_ctl_t link_ctl;
    int n_mismatch = 0;
    int n_tests = 0;
    int cycles = 0;

    link_slot_regs dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .hotplug_strap(hotplug_strap), .link_state(state_in),
        .link_ctl(link_ctl)
    );

    ////////////////////////////////////////////////////////////////////////
    // clock and hang guard; the run needs a few hundred cycles at most
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            chk(32'(cycles), 32'h0000_0000);
            give_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // expected words built from the field constants, never from the dut
    function automatic logic [31:0] cap_exp();
        return {link_slot_pkg::PORT_NUM_RST, 6'h00, link_slot_pkg::L1_LAT_RST,
            link_slot_pkg::L0S_LAT_RST, link_slot_pkg::ASPM_SUP_RST,
            link_slot_pkg::MAX_WIDTH_RST, link_slot_pkg::MAX_SPEED_RST};
    endfunction : cap_exp

    function automatic logic [31:0] ctl_exp(logic [1:0] a, logic cc,
        logic es, link_slot_pkg::link_state_t s);
        return {3'h0, link_slot_pkg::SLOT_CLK_RST, s.training, s.train_err,
            s.neg_width, link_slot_pkg::LINK_SPEED_RST, 8'h00, es, cc,
            4'h0, a};
    endfunction : ctl_exp

    function automatic logic [31:0] slot_exp(logic h);
        return {link_slot_pkg::SLOT_NUM_RST, 2'h0,
            link_slot_pkg::PWR_SCALE_RST, link_slot_pkg::PWR_VAL_RST,
            h, 1'b0, h, h, h, 1'b0, h};
    endfunction : slot_exp

    ////////////////////////////////////////////////////////////////////////
    // apb master: setup, access, hold until pready seen at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] d, input logic [3:0] s,
        output logic [31:0] r, output logic e);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        pwrite <= 1'b0;
        if (n >= 20) begin
            chk(32'h0000_0000, 32'h0000_0001);
        end
    endtask : apb

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            n_mismatch++;
        end
    endtask : chk

    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0000_0000, 4'h0, r, e);
        chk(r, x);
        chk({31'h0, e}, 32'h0000_0000);
    endtask : rd

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] s);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, s, r, e);
        chk({31'h0, e}, 32'h0000_0000);
    endtask : wr

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : give_verdict

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        logic [31:0] r;
        logic e;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        pstrb = 4'h0;
        hotplug_strap = 1'b1;
        state_in = '{link_slot_pkg::WIDTH_X1, 1'b0, 1'b0};
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        // strap synchroniser needs four edges after release
        repeat (6) @(posedge pclk);
        rd(8'hbc, cap_exp());
        rd(8'hc0, ctl_exp(2'h0, 1'b0, 1'b0, state_in));
        rd(8'hc4, slot_exp(1'b1));
        $display("test reset_values done");
        // every power level code, with read-only control bits forced high
        for (int i = 0; i < 4; i++) begin
            k = i[1:0];
            wr(8'hc0, {24'hff_ffff, k[0], k[1], 4'hf, k}, 4'hf);
            rd(8'hc0, ctl_exp(k, k[1], k[0], state_in));
            chk(32'(link_ctl), {28'h0, k[0], k[1], k});
        end
        $display("test control_codes done");
        // byte 0 strobe low: nothing may change
        wr(8'hc0, 32'h0000_0000, 4'he);
        rd(8'hc0, ctl_exp(2'h3, 1'b1, 1'b1, state_in));
        wr(8'hbc, 32'h0000_0000, 4'hf);
        wr(8'hc4, 32'h0000_0000, 4'hf);
        rd(8'hbc, cap_exp());
        rd(8'hc4, slot_exp(1'b1));
        $display("test read_only_writes done");
        // unmapped address answers with an error and zero data
        apb(1'b0, 8'hb8, 32'h0000_0000, 4'h0, r, e);
        chk(r, 32'h0000_0000);
        chk({31'h0, e}, 32'h0000_0001);
        // an unmapped write is refused and must not reach the control bits
        apb(1'b1, 8'hb8, 32'h0000_0000, 4'hf, r, e);
        chk({31'h0, e}, 32'h0000_0001);
        rd(8'hc0, ctl_exp(2'h3, 1'b1, 1'b1, state_in));
        $display("test unmapped done");
        state_in <= '{link_slot_pkg::WIDTH_X4, 1'b1, 1'b1};
        @(posedge pclk);
        rd(8'hc0, ctl_exp(2'h3, 1'b1, 1'b1, state_in));
        $display("test link_state done");
        hotplug_strap <= 1'b0;
        repeat (8) @(posedge pclk);
        rd(8'hc4, slot_exp(1'b0));
        $display("test strap_off done");
        // a reset in mid-run must bring the written control bits back
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        rd(8'hc0, ctl_exp(2'h0, 1'b0, 1'b0, state_in));
        chk(32'(link_ctl), 32'h0000_0000);
        $display("test mid_reset done");
        give_verdict();
    end

endmodule : test_link_slot_regs
